// File: sbcms_pkg.sv
package sbcms_pkg;

   // clock rate and time figures; cycle counts derive from them
   localparam int SYS_CLK_MHZ = 100;
   localparam int WAKE_FILT_TIME_US = 16;
   localparam int RESET_PULSE_TIME_US = 2000;
   localparam int RESET_CLAMP_TIME_US = 128000;
   localparam int POWERUP_TIME_US = 1000;
   localparam int WAKE_FILT_CYCLES = WAKE_FILT_TIME_US * SYS_CLK_MHZ;
   localparam int RESET_PULSE_CYCLES = RESET_PULSE_TIME_US * SYS_CLK_MHZ;
   localparam int RESET_CLAMP_CYCLES = RESET_CLAMP_TIME_US * SYS_CLK_MHZ;
   localparam int POWERUP_CYCLES = POWERUP_TIME_US * SYS_CLK_MHZ;
   localparam int TIMER_W = 24;

   // wake edge selection field encoding
   localparam logic [1:0] WAKE_SEL_OFF = 2'h0;
   localparam logic [1:0] WAKE_SEL_RISE = 2'h1;
   localparam logic [1:0] WAKE_SEL_FALL = 2'h2;
   localparam logic [1:0] WAKE_SEL_BOTH = 2'h3;

   // one-hot operating modes
   typedef enum logic [9:0] {
      SBCMS_SHUTDOWN = 10'h001,
      SBCMS_CONFIG = 10'h002,
      SBCMS_POWERUP = 10'h004,
      SBCMS_RESET = 10'h008,
      SBCMS_STARTUP = 10'h010,
      SBCMS_NORMAL = 10'h020,
      SBCMS_STANDBY = 10'h040,
      SBCMS_SLEEP = 10'h080,
      SBCMS_FLASH = 10'h100,
      SBCMS_FAILSAFE = 10'h200
   } sbcms_mode_t;

   typedef enum logic [2:0] {
      SBCMS_CFG_1,
      SBCMS_CFG_2,
      SBCMS_CFG_3,
      SBCMS_CFG_4,
      SBCMS_CFG_SWDEV
   } sbcms_cfg_t;

   // true when an edge matches the selection field
   function automatic logic sbcms_edge_hit(input logic [1:0] sel,
                                           input logic rise,
                                           input logic fall);
      sbcms_edge_hit = (rise && (sel == WAKE_SEL_RISE ||
                                 sel == WAKE_SEL_BOTH)) ||
                       (fall && (sel == WAKE_SEL_FALL ||
                                 sel == WAKE_SEL_BOTH));
   endfunction : sbcms_edge_hit

   // configuration from strap levels and the fast failsafe bit
   function automatic sbcms_cfg_t sbcms_cfg_decode(input logic wd_strap,
                                                   input logic fs_strap,
                                                   input logic fast);
      if (wd_strap) begin
         sbcms_cfg_decode = SBCMS_CFG_SWDEV;
      end else if (fast) begin
         sbcms_cfg_decode = fs_strap ? SBCMS_CFG_1 : SBCMS_CFG_2;
      end else begin
         sbcms_cfg_decode = fs_strap ? SBCMS_CFG_3 : SBCMS_CFG_4;
      end
   endfunction : sbcms_cfg_decode

   // modes in which the wake level is mirrored and edges raise irq
   function automatic logic sbcms_is_active(input sbcms_mode_t m);
      sbcms_is_active = (m == SBCMS_STARTUP) || (m == SBCMS_NORMAL) ||
                        (m == SBCMS_STANDBY) || (m == SBCMS_FLASH);
   endfunction : sbcms_is_active

endpackage : sbcms_pkg

// File: sbcms_wake_filter.sv
`timescale 1ns/10ps
module sbcms_wake_filter #(
   parameter int FILT_CYCLES = 1600
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic local_wake_input,
   output logic level,
   output logic rise,
   output logic fall,
   output logic pullup_en,
   output logic pulldown_en
);
   localparam int CW = $clog2(FILT_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYCLES - 1);

   logic sync1_reg;
   logic sync2_reg;
   logic [CW-1:0] cnt_reg;

   // two-stage synchroniser; only the second stage is looked at
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= local_wake_input;
         sync2_reg <= sync1_reg;
      end
   end

   // a new level must stand for the whole filter time before it is taken
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         level <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
         pullup_en <= 1'b0;
         pulldown_en <= 1'b1;
      end else begin
         rise <= 1'b0;
         fall <= 1'b0;
         if (sync2_reg == level) begin
            cnt_reg <= '0;
         end else if (cnt_reg == CNT_LAST) begin
            cnt_reg <= '0;
            level <= sync2_reg;
            rise <= sync2_reg;
            fall <= !sync2_reg;
            pullup_en <= sync2_reg;
            pulldown_en <= !sync2_reg;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end
endmodule : sbcms_wake_filter

// File: sbcms_mode_sequencer.sv
`timescale 1ns/10ps
module sbcms_mode_sequencer
   import sbcms_pkg::*;
#(
   parameter int FILT_CYCLES = WAKE_FILT_CYCLES,
   parameter int PULSE_CYCLES = RESET_PULSE_CYCLES,
   parameter int CLAMP_CYCLES = RESET_CLAMP_CYCLES,
   parameter int PWRUP_CYCLES = POWERUP_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic local_wake_input,
   input wire logic [1:0] wake_edge_select,
   input wire logic wake_flag_clear,
   input wire logic mid_supply_por_low,
   input wire logic mid_supply_por_high,
   input wire logic main_above_reset_level,
   input wire logic main_above_highest_reset,
   input wire logic main_above_failure_level,
   input wire logic watchdog_strap,
   input wire logic failsafe_strap,
   input wire logic fast_failsafe_select,
   input wire logic mcu_reset_in_n,
   input wire logic watchdog_service,
   input wire logic service_req_flash,
   input wire logic watchdog_missed,
   input wire logic req_config,
   input wire logic req_normal,
   input wire logic req_standby,
   input wire logic req_sleep,
   input wire logic req_flash_enter,
   input wire logic req_flash_exit,
   input wire logic req_reset,
   input wire logic req_unauthorized,
   input wire logic bus_wake,
   input wire logic aux_regulator_request,
   input wire logic write_req,
   input wire logic write_is_mode_ctrl,
   output sbcms_mode_t mode_state,
   output logic converter_on,
   output logic aux_regulator_on,
   output logic bus_pins_passive,
   output logic serial_enable,
   output logic receive_data_outputs_high,
   output logic mcu_reset_out_n,
   output logic mcu_reset_oe,
   output logic main_supply_undervolt_n,
   output logic watchdog_run,
   output logic watchdog_timeout_mode,
   output logic wake_pullup_en,
   output logic wake_pulldown_en,
   output logic wake_input_level_status,
   output logic wake_input_event_flag,
   output logic wake_irq,
   output logic watchdog_irq,
   output logic watchdog_strap_status,
   output logic failsafe_strap_status,
   output sbcms_cfg_t config_sel,
   output logic failsafe_outputs,
   output logic reset_clamp_event,
   output logic write_accept
);
   localparam logic [TIMER_W-1:0] PULSE_LAST = TIMER_W'(PULSE_CYCLES - 1);
   localparam logic [TIMER_W-1:0] CLAMP_LAST = TIMER_W'(CLAMP_CYCLES - 1);
   localparam logic [TIMER_W-1:0] PWRUP_LAST = TIMER_W'(PWRUP_CYCLES - 1);
   localparam logic [TIMER_W-1:0] TIMER_MAX = '1;

   sbcms_mode_t state_reg;
   sbcms_mode_t state_next;
   logic core_rst_n;
   logic wake_level;
   logic wake_rise;
   logic wake_fall;
   logic wake_hit;
   logic any_edge;
   logic [TIMER_W-1:0] timer_reg;
   logic [TIMER_W-1:0] clamp_reg;
   logic released_reg;
   logic released_next;
   logic clamp_hit;
   logic miss_seen_reg;
   logic wd_to_reset;
   logic wd_to_failsafe;
   logic wd_fso;
   logic ext_reset;
   logic fso_set;
   logic is_swdev;

   // mid supply undervoltage acts as reset, so shut-down entry needs no clock
   assign core_rst_n = rst_n & ~mid_supply_por_low;

   sbcms_wake_filter #(
      .FILT_CYCLES(FILT_CYCLES)
   ) u_wake (
      .sys_clk(sys_clk),
      .rst_n(core_rst_n),
      .local_wake_input(local_wake_input),
      .level(wake_level),
      .rise(wake_rise),
      .fall(wake_fall),
      .pullup_en(wake_pullup_en),
      .pulldown_en(wake_pulldown_en)
   );

   // edge qualification; fail-safe always listens on both edges
   assign wake_hit = sbcms_edge_hit(wake_edge_select, wake_rise,
                                    wake_fall);
   assign any_edge = wake_rise | wake_fall;
   assign is_swdev = (config_sel == SBCMS_CFG_SWDEV);

   // pin is not driven by us in these modes, so a low is external
   assign ext_reset = !mcu_reset_in_n && sbcms_is_active(state_reg);

   // clamp detected once, when the external low outlasts the timeout
   assign clamp_hit = (state_reg == SBCMS_RESET) && released_reg &&
                      !mcu_reset_in_n && (clamp_reg == CLAMP_LAST);

   // watchdog miss reaction; a second miss counts only for configs 3 and 4
   always_comb begin
      wd_to_reset = 1'b0;
      wd_to_failsafe = 1'b0;
      wd_fso = 1'b0;
      unique case (config_sel)
         SBCMS_CFG_1: begin
            wd_to_reset = 1'b1;
            wd_fso = 1'b1;
         end
         SBCMS_CFG_2: begin
            wd_to_failsafe = 1'b1;
         end
         SBCMS_CFG_3: begin
            wd_to_reset = 1'b1;
            wd_fso = miss_seen_reg;
         end
         SBCMS_CFG_4: begin
            wd_to_reset = !miss_seen_reg;
            wd_to_failsafe = miss_seen_reg;
            wd_fso = miss_seen_reg;
         end
         SBCMS_CFG_SWDEV: begin
         end
      endcase
   end

   // mode transitions; undervoltage outranks every serial request
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         SBCMS_SHUTDOWN: begin
            if (mid_supply_por_high) begin
               state_next = SBCMS_CONFIG;
            end
         end
         SBCMS_CONFIG: begin
            state_next = SBCMS_POWERUP;
         end
         SBCMS_POWERUP: begin
            if (main_above_reset_level) begin
               state_next = SBCMS_RESET;
            end else if (timer_reg >= PWRUP_LAST &&
                         !main_above_failure_level) begin
               state_next = SBCMS_FAILSAFE;
            end
         end
         SBCMS_RESET: begin
            if (!main_above_reset_level) begin
               state_next = SBCMS_POWERUP;
            end else if (clamp_hit && (config_sel == SBCMS_CFG_2 ||
                                       config_sel == SBCMS_CFG_4)) begin
               state_next = SBCMS_FAILSAFE;
            end else if (released_reg && mcu_reset_in_n) begin
               state_next = SBCMS_STARTUP;
            end
         end
         SBCMS_STARTUP, SBCMS_NORMAL, SBCMS_STANDBY, SBCMS_FLASH: begin
            if (!main_above_reset_level) begin
               state_next = SBCMS_POWERUP;
            end else if (ext_reset) begin
               state_next = SBCMS_RESET;
            end else if (watchdog_missed && wd_to_failsafe) begin
               state_next = SBCMS_FAILSAFE;
            end else if (watchdog_missed && wd_to_reset) begin
               state_next = SBCMS_RESET;
            end else if (req_config && (state_reg == SBCMS_STARTUP ||
                                        state_reg == SBCMS_NORMAL)) begin
               state_next = SBCMS_CONFIG;
            end else if (req_reset || req_unauthorized) begin
               state_next = SBCMS_RESET;
            end else if (state_reg == SBCMS_STARTUP) begin
               if (watchdog_service) begin
                  state_next = service_req_flash ? SBCMS_FLASH :
                               SBCMS_NORMAL;
               end
            end else if (state_reg == SBCMS_FLASH) begin
               if (req_flash_exit) begin
                  state_next = SBCMS_RESET;
               end
            end else if (state_reg == SBCMS_NORMAL) begin
               if (req_flash_enter) begin
                  state_next = SBCMS_RESET;
               end else if (req_sleep) begin
                  state_next = SBCMS_SLEEP;
               end else if (req_standby) begin
                  state_next = SBCMS_STANDBY;
               end
            end else if (req_normal) begin
               state_next = SBCMS_NORMAL;
            end
         end
         SBCMS_SLEEP: begin
            if (wake_hit || bus_wake) begin
               state_next = SBCMS_POWERUP;
            end
         end
         SBCMS_FAILSAFE: begin
            if (any_edge || bus_wake) begin
               state_next = SBCMS_POWERUP;
            end
         end
         default: begin
            state_next = SBCMS_SHUTDOWN;
         end
      endcase
   end

   // mode register; a corrupted one-hot code falls back to shut-down
   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         state_reg <= SBCMS_SHUTDOWN;
      end else begin
         state_reg <= state_next;
      end
   end

   // time spent in the current mode, saturating
   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         timer_reg <= '0;
      end else if (state_next != state_reg) begin
         timer_reg <= '0;
      end else if (timer_reg != TIMER_MAX) begin
         timer_reg <= timer_reg + 1'b1;
      end
   end

   // reset pin let go once the pulse time has run out in reset mode
   assign released_next = (state_next == SBCMS_RESET) &&
                          (state_reg == SBCMS_RESET) &&
                          (released_reg || timer_reg >= PULSE_LAST);

   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         released_reg <= 1'b0;
      end else begin
         released_reg <= released_next;
      end
   end

   // external low after release; clamp event is a single pulse
   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         clamp_reg <= '0;
         reset_clamp_event <= 1'b0;
      end else begin
         reset_clamp_event <= clamp_hit;
         if (state_reg != SBCMS_RESET || !released_reg || mcu_reset_in_n) begin
            clamp_reg <= '0;
         end else if (clamp_reg != TIMER_MAX) begin
            clamp_reg <= clamp_reg + 1'b1;
         end
      end
   end

   // strap latching only in configuration; frozen otherwise
   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         config_sel <= SBCMS_CFG_4;
         watchdog_strap_status <= 1'b0;
      end else if (state_reg == SBCMS_CONFIG) begin
         config_sel <= sbcms_cfg_decode(watchdog_strap, failsafe_strap,
                                        fast_failsafe_select);
         watchdog_strap_status <= watchdog_strap;
      end
   end

   // failsafe strap status follows the pin live only for development
   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         failsafe_strap_status <= 1'b0;
      end else if (state_reg == SBCMS_CONFIG || is_swdev) begin
         failsafe_strap_status <= failsafe_strap;
      end
   end

   // first watchdog miss remembered; set wins over a service
   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         miss_seen_reg <= 1'b0;
      end else if (watchdog_missed && sbcms_is_active(state_reg)) begin
         miss_seen_reg <= 1'b1;
      end else if (watchdog_service || state_reg == SBCMS_CONFIG) begin
         miss_seen_reg <= 1'b0;
      end
   end

   // failsafe outputs are sticky until the next supply loss
   assign fso_set = (watchdog_missed && sbcms_is_active(state_reg) &&
                     wd_fso) ||
                    (clamp_hit && !is_swdev) ||
                    (ext_reset && state_reg == SBCMS_STARTUP && !is_swdev);

   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         failsafe_outputs <= 1'b0;
      end else if (fso_set || state_next == SBCMS_FAILSAFE) begin
         failsafe_outputs <= 1'b1;
      end
   end

   // development config only flags a watchdog miss
   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         watchdog_irq <= 1'b0;
      end else begin
         watchdog_irq <= watchdog_missed && is_swdev &&
                         sbcms_is_active(state_reg);
      end
   end

   // wake handling: edges ignored while the device is not listening
   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         wake_input_event_flag <= 1'b0;
         wake_irq <= 1'b0;
         wake_input_level_status <= 1'b0;
      end else begin
         wake_irq <= wake_hit && sbcms_is_active(state_reg);
         if (sbcms_is_active(state_reg)) begin
            wake_input_level_status <= wake_level;
         end
         if (wake_hit && (sbcms_is_active(state_reg) ||
                          state_reg == SBCMS_SLEEP)) begin
            wake_input_event_flag <= 1'b1;
         end else if (wake_flag_clear) begin
            wake_input_event_flag <= 1'b0;
         end
      end
   end

   // start-up writes pass only the mode frame when failsafe is active
   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         write_accept <= 1'b0;
      end else if (state_reg == SBCMS_STARTUP) begin
         write_accept <= write_req &&
                         (!failsafe_outputs || write_is_mode_ctrl);
      end else begin
         write_accept <= write_req && sbcms_is_active(state_reg);
      end
   end

   // outputs decoded from the next mode so they line up with mode_state
   always_ff @(posedge sys_clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         mode_state <= SBCMS_SHUTDOWN;
         converter_on <= 1'b0;
         aux_regulator_on <= 1'b0;
         bus_pins_passive <= 1'b1;
         serial_enable <= 1'b0;
         receive_data_outputs_high <= 1'b1;
         mcu_reset_out_n <= 1'b0;
         mcu_reset_oe <= 1'b1;
         main_supply_undervolt_n <= 1'b0;
         watchdog_run <= 1'b0;
         watchdog_timeout_mode <= 1'b0;
      end else begin
         mode_state <= state_next;
         mcu_reset_out_n <= 1'b0;
         converter_on <= sbcms_is_active(state_next) ||
                         state_next == SBCMS_POWERUP ||
                         state_next == SBCMS_RESET;
         // aux keeps its state through power-up and reset
         if (sbcms_is_active(state_next)) begin
            aux_regulator_on <= aux_regulator_request;
         end else if (state_next != SBCMS_POWERUP &&
                      state_next != SBCMS_RESET) begin
            aux_regulator_on <= 1'b0;
         end
         bus_pins_passive <= !sbcms_is_active(state_next) &&
                             state_next != SBCMS_SLEEP &&
                             state_next != SBCMS_FAILSAFE;
         serial_enable <= sbcms_is_active(state_next);
         receive_data_outputs_high <= !sbcms_is_active(state_next);
         mcu_reset_oe <= !sbcms_is_active(state_next) &&
                         !released_next;
         main_supply_undervolt_n <= (sbcms_is_active(state_next) ||
                                     state_next == SBCMS_RESET) &&
                                    main_above_highest_reset;
         watchdog_run <= sbcms_is_active(state_next);
         watchdog_timeout_mode <= state_next == SBCMS_STARTUP ||
                                  state_next == SBCMS_FLASH;
      end
   end
endmodule : sbcms_mode_sequencer

// File: sbcms_mcu_model.sv
`timescale 1ns/10ps
// mcu end of the open-drain reset pin, pulled up when nobody pulls
module sbcms_mcu_model (
   input wire logic mcu_reset_oe,
   input wire logic hold_low,
   output logic mcu_reset_in_n
);
   // hold_low plays a slow mcu or a pin clamped low by a fault
   assign mcu_reset_in_n = !(mcu_reset_oe || hold_low);
endmodule : sbcms_mcu_model

// File: sbcms_mode_sequencer_chk.sv
`timescale 1ns/10ps
module sbcms_mode_sequencer_chk
   import sbcms_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic mid_supply_por_low,
   input wire logic main_above_reset_level,
   input wire logic mcu_reset_in_n,
   input wire logic [1:0] wake_edge_select,
   input wire sbcms_mode_t mode_state,
   input wire sbcms_cfg_t config_sel,
   input wire logic converter_on,
   input wire logic serial_enable,
   input wire logic receive_data_outputs_high,
   input wire logic main_supply_undervolt_n,
   input wire logic mcu_reset_oe,
   input wire logic wake_input_event_flag,
   input wire logic wake_irq,
   input wire logic failsafe_outputs,
   input wire logic reset_clamp_event
);
   // both resets are asynchronous, so neither may see a check
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n || mid_supply_por_low);
   logic act;
   assign act = mode_state inside {SBCMS_STARTUP, SBCMS_NORMAL,
                                   SBCMS_STANDBY, SBCMS_FLASH};
   property p_shut; mode_state == SBCMS_SHUTDOWN |-> !converter_on &&
      !serial_enable && receive_data_outputs_high && !main_supply_undervolt_n;
   endproperty
   a_shut: assert property (p_shut) else $error("shutdown outputs");
   property p_cfg; mode_state == SBCMS_CONFIG |=> mode_state == SBCMS_POWERUP;
   endproperty
   a_cfg: assert property (p_cfg) else $error("config not left");
   property p_pwr; mode_state == SBCMS_POWERUP |-> converter_on &&
      !serial_enable && mcu_reset_oe && receive_data_outputs_high;
   endproperty
   a_pwr: assert property (p_pwr) else $error("powerup outputs");
   property p_rst; $rose(mode_state == SBCMS_RESET) |-> mcu_reset_oe [*8];
   endproperty
   a_rst: assert property (p_rst) else $error("reset pulse short");
   property p_rel; mode_state == SBCMS_RESET && !mcu_reset_oe &&
      mcu_reset_in_n && main_above_reset_level |=> mode_state == SBCMS_STARTUP;
   endproperty
   a_rel: assert property (p_rel) else $error("no start-up");
   property p_wake; $rose(wake_input_event_flag) |->
      $past(wake_edge_select) != WAKE_SEL_OFF;
   endproperty
   a_wake: assert property (p_wake) else $error("flag unselected");
   property p_irq; wake_irq |-> $past(act);
   endproperty
   a_irq: assert property (p_irq) else $error("irq out of mode");
   property p_clamp; reset_clamp_event && (config_sel == SBCMS_CFG_2 ||
      config_sel == SBCMS_CFG_4) |-> mode_state == SBCMS_FAILSAFE &&
      failsafe_outputs;
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp reaction");
   c_start: cover property (mode_state == SBCMS_STARTUP);
   c_clamp: cover property (reset_clamp_event);
   c_irq: cover property (wake_irq);
endmodule : sbcms_mode_sequencer_chk

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import sbcms_pkg::*;
   logic sys_clk = 1'h0, rst_n = 1'h0, local_wake_input = 1'h0;
   logic [1:0] wake_edge_select = WAKE_SEL_BOTH;
   logic wake_flag_clear = 1'h0, mid_supply_por_low = 1'h0, hold_low = 1'h0;
   logic mid_supply_por_high = 1'h1, main_above_reset_level = 1'h1;
   logic main_above_highest_reset = 1'h1, main_above_failure_level = 1'h1;
   logic watchdog_strap = 1'h0, failsafe_strap = 1'h0, req_config = 1'h0;
   logic fast_failsafe_select = 1'h0, watchdog_service = 1'h0;
   logic service_req_flash = 1'h0, watchdog_missed = 1'h0, req_reset = 1'h0;
   logic req_normal = 1'h0, req_standby = 1'h0, req_sleep = 1'h0;
   logic req_flash_enter = 1'h0, req_flash_exit = 1'h0, write_req = 1'h0;
   logic req_unauthorized = 1'h0, bus_wake = 1'h0;
   logic aux_regulator_request = 1'h0, write_is_mode_ctrl = 1'h0;
   wire mcu_reset_in_n;
   sbcms_mode_t mode_state, prev = SBCMS_SHUTDOWN, exp_q[$];
   sbcms_cfg_t config_sel;
   logic converter_on, aux_regulator_on, bus_pins_passive, serial_enable;
   logic receive_data_outputs_high, mcu_reset_out_n, mcu_reset_oe;
   logic main_supply_undervolt_n, watchdog_run, watchdog_timeout_mode;
   logic wake_pullup_en, wake_pulldown_en, wake_input_level_status;
   logic wake_input_event_flag, wake_irq, watchdog_irq, watchdog_strap_status;
   logic failsafe_strap_status, failsafe_outputs, reset_clamp_event;
   logic write_accept;
   logic [2:0] cfg_exp;
   int err_count = 0, compares = 0, cyc = 0;
   always #5 sys_clk = ~sys_clk;
   // short counts keep runs brief
   sbcms_mode_sequencer #(.FILT_CYCLES(4), .PULSE_CYCLES(8),
      .CLAMP_CYCLES(16), .PWRUP_CYCLES(20)) dut_u (.*);
   sbcms_mcu_model mcu_u (.mcu_reset_oe, .hold_low, .mcu_reset_in_n);
   task automatic chk(string n, logic [9:0] e, logic [9:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task go(int n);
      repeat (n) @(negedge sys_clk);
   endtask : go
   task automatic pulse(ref logic s);
      s = 1'h1;
      go(1);
      s = 1'h0;
   endtask : pulse
   task wm(sbcms_mode_t m);
      for (int i = 0; i < 300 && mode_state !== m; i++) go(1);
   endtask : wm
   task boot(logic c);
      if (c) exp_q.push_back(SBCMS_CONFIG);
      exp_q.push_back(SBCMS_POWERUP);
      exp_q.push_back(SBCMS_RESET);
      exp_q.push_back(SBCMS_STARTUP);
   endtask : boot
   function logic [2:0] cfg_of();
      return watchdog_strap ? 3'h4 :
         {1'h0, !fast_failsafe_select, !failsafe_strap};
   endfunction : cfg_of
   task tally_and_finish;
      if (exp_q.size()) err_count++;
      $display("checks %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // each mode change takes the oldest note off the queue
   always @(negedge sys_clk) begin
      cyc++;
      if (cyc > 3000) begin
         err_count++;
         tally_and_finish();
      end
      if (mode_state !== prev) begin
         prev = mode_state;
         chk("mode", exp_q.size() ? exp_q.pop_front() : 10'h0,
             mode_state);
      end
   end
   initial begin
      void'($urandom(32'h2ff0));
      {watchdog_strap, fast_failsafe_select, failsafe_strap} = 3'($urandom());
      cfg_exp = cfg_of();
      boot(1'h1);
      go(8);
      rst_n = 1'h1;
      wm(SBCMS_STARTUP);
      chk("cfg", cfg_exp, config_sel);
      chk("wd strap", cfg_exp[2], watchdog_strap_status);
      failsafe_strap = !failsafe_strap;
      fast_failsafe_select = !fast_failsafe_select;
      go(3);
      chk("cfg held", cfg_exp, config_sel);
      chk("fs", failsafe_strap ^ !cfg_exp[2], failsafe_strap_status);
      pulse(write_req);
      chk("wr", 1'h1, write_accept);
      wake_edge_select = 2'($urandom());
      local_wake_input = 1'h1;
      go(10);
      chk("wake lvl", 1'h1, wake_input_level_status);
      chk("wake flag", wake_edge_select[0], wake_input_event_flag);
      chk("pullup", 1'h1, wake_pullup_en);
      repeat (6) begin
         {aux_regulator_request, main_above_highest_reset} = 2'($urandom());
         go(1);
      end
      chk("outs", {aux_regulator_request, 3'h6}, {aux_regulator_on,
          watchdog_run, watchdog_timeout_mode, bus_pins_passive});
      exp_q.push_back(SBCMS_RESET);
      exp_q.push_back(SBCMS_STARTUP);
      pulse(req_reset);
      go(2);
      wm(SBCMS_STARTUP);
      exp_q.push_back(SBCMS_NORMAL);
      pulse(watchdog_service);
      boot(1'h0);
      main_above_reset_level = 1'h0;
      go(3);
      main_above_reset_level = 1'h1;
      wm(SBCMS_STARTUP);
      cfg_exp = cfg_of();
      boot(1'h1);
      pulse(req_config);
      go(2);
      wm(SBCMS_STARTUP);
      chk("cfg new", cfg_exp, config_sel);
      exp_q.push_back(SBCMS_RESET);
      if (cfg_exp[0]) begin
         exp_q.push_back(SBCMS_FAILSAFE);
         boot(1'h0);
      end else exp_q.push_back(SBCMS_STARTUP);
      hold_low = 1'h1;
      go(3);
      chk("fso", cfg_exp != 3'h4, failsafe_outputs);
      go(40);
      hold_low = 1'h0;
      local_wake_input = 1'h0;
      go(20);
      wm(SBCMS_STARTUP);
      chk("fso clamp", cfg_exp != 3'h4, failsafe_outputs);
      write_is_mode_ctrl = 1'($urandom());
      pulse(write_req);
      chk("wr2", cfg_exp == 3'h4 || write_is_mode_ctrl, write_accept);
      exp_q.push_back(SBCMS_SHUTDOWN);
      mid_supply_por_high = 1'h0;
      mid_supply_por_low = 1'h1;
      #1;
      chk("shut", 10'h1, {converter_on, serial_enable,
         main_supply_undervolt_n, receive_data_outputs_high});
      go(2);
      mid_supply_por_low = 1'h0;
      go(3);
      boot(1'h1);
      mid_supply_por_high = 1'h1;
      go(2);
      wm(SBCMS_STARTUP);
      for (int k = 0; k < 2; k++) begin
         if (cfg_exp == 3'(2 * k + 1)) exp_q.push_back(SBCMS_FAILSAFE);
         else if (cfg_exp != 3'h4 && !(k && cfg_exp == 3'h1)) begin
            exp_q.push_back(SBCMS_RESET);
            exp_q.push_back(SBCMS_STARTUP);
         end
         pulse(watchdog_missed);
         chk("wd irq", cfg_exp == 3'h4, watchdog_irq);
         go(12);
      end
      chk("fso wd", cfg_exp != 3'h4, failsafe_outputs);
      tally_and_finish();
   end
endmodule : tb_top
bind sbcms_mode_sequencer sbcms_mode_sequencer_chk chk_u (.*);
